// ==== verilog/offload_engine_power_state_control.sv ====
// Power-state and wake sequencer of the offload subsystem
`timescale 1ns/100ps
`include "offload_pwr_cfg.svh"
module offload_engine_power_state_control #(
    parameter int NFUNC  = 4,
    parameter int NBANK  = 4,
    parameter int NBLOCK = 8,
    parameter int NIRQ   = 8,
    parameter int RESUME_CYCLES = `OPW_RESUME_CYCLES
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_resetn,
    input  wire logic [NFUNC-1:0][1:0]         i_func_dstate,
    input  wire logic [NFUNC-1:0]              i_idle_request_deepest,
    input  wire logic                          i_core_idle,
    input  wire logic                          i_ips_idle,
    input  wire logic                          i_wait_for_interrupt_instruction,
    input  wire logic [NBLOCK-1:0]             i_block_idle,
    input  wire logic                          i_retain_sram,
    input  wire logic [NBANK-1:0]              i_bank_keep,
    input  wire logic                          i_enter_inaccessible,
    input  wire logic                          i_timer_irq,
    input  wire logic                          i_gpio_wake,
    input  wire logic                          i_host_access,
    input  wire logic [NIRQ-1:0]               i_irq,
    input  wire logic                          i_irq_clear,
    input  wire logic                          i_wrapper_power_good,
    input  wire logic                          i_fw_rail_request,
    input  wire logic                          i_fw_host_wake,
    input  wire logic                          i_host_in_sleep,
    input  wire logic [NFUNC-1:0]              i_wake_func,
    output offload_pwr_pkg::pwr_state_t        o_state,
    output logic [NBLOCK-1:0]                  o_block_clk_en,
    output logic                               o_core_clk_en,
    output logic                               o_trunk_clk_en,
    output logic                               o_logic_power_en,
    output offload_pwr_pkg::bank_mode_t [NBANK-1:0] o_bank_mode,
    output logic                               o_wrapper_power_req,
    output logic                               o_fabric_accessible,
    output logic [NIRQ-1:0]                    o_irq_pending,
    output logic                               o_rail_request,
    output logic [NFUNC-1:0]                   o_wake_set_bit,
    output logic                               o_wake_assert_message,
    output logic                               o_resume_late
);
    import offload_pwr_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int NS = 4 + NIRQ;
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic          timer_s, gpio_s, host_s, pg_s;
    logic [NIRQ-1:0] irq_s;

    // Pins from outside the clock domain, two flops each
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_irq, i_wrapper_power_good, i_host_access, i_gpio_wake, i_timer_irq};
            sync2_reg <= sync1_reg;
        end
    end
    assign timer_s = sync2_reg[0];
    assign gpio_s  = sync2_reg[1];
    assign host_s  = sync2_reg[2];
    assign pg_s    = sync2_reg[3];
    assign irq_s   = sync2_reg[NS-1:4];

    // ****************************************************************
    // State decision
    // ****************************************************************
    pwr_state_t state_reg, state_next;
    logic       all_idle_req, others_off, ipc_off, deep_wake, any_wake;
    logic [15:0] settle_reg;

    // Function 0 is the host messaging function
    always_comb begin
        all_idle_req = &i_idle_request_deepest;
        ipc_off      = (i_func_dstate[0] == `OPW_DSTATE_OFF);
        others_off   = 1'b1;
        for (int f = 1; f < NFUNC; f++) begin
            if (i_func_dstate[f] != `OPW_DSTATE_OFF) begin
                others_off = 1'b0;
            end
        end
    end

    assign deep_wake = timer_s | gpio_s | host_s;
    assign any_wake  = deep_wake | (|irq_s);

    // Timer, GPIO and host wake beat entry except ST_APG to ST_IAPG, where entry wins; interrupts only block ST_ON to ST_BLOCK_CG to ST_TRUNK_CG
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_ON: begin
                if (ipc_off && others_off && i_core_idle && i_ips_idle && !deep_wake) begin
                    state_next = ST_APG;
                end else if (!all_idle_req && i_core_idle && !any_wake) begin
                    state_next = ST_BLOCK_CG;
                end else if (all_idle_req && i_core_idle && i_ips_idle && !deep_wake) begin
                    state_next = ST_TRUNK_CG;                          // Settle before memories drop
                end
            end
            ST_BLOCK_CG: begin
                if (any_wake || !i_core_idle || (ipc_off && others_off && i_ips_idle)) begin
                    state_next = ST_ON;
                end else if (all_idle_req && i_ips_idle) begin
                    state_next = ST_TRUNK_CG;
                end
            end
            ST_TRUNK_CG: begin
                if (deep_wake || !all_idle_req) begin
                    state_next = ST_ON;
                end else if (settle_reg == 16'h0000) begin
                    state_next = i_retain_sram ? ST_RET : ST_DEEP;
                end
            end
            ST_RET, ST_DEEP: begin
                if (deep_wake || !all_idle_req) begin
                    state_next = ST_ON;
                end else if (pg_s == 1'b0) begin
                    state_next = ST_APG;
                end
            end
            ST_APG: begin
                if (i_enter_inaccessible) begin
                    state_next = ST_IAPG;
                end else if (deep_wake || !ipc_off && !all_idle_req) begin
                    state_next = ST_ON;
                end
            end
            ST_IAPG: state_next = ST_IAPG;
        endcase
    end

    // Only reset leaves the inaccessible state
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_ON;
        end else if (state_reg == ST_APG && state_next == ST_ON && !pg_s) begin
            state_reg <= ST_APG;                                       // Wait for rail
        end else begin
            state_reg <= state_next;
        end
    end

    // Settling count before memories are gated
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            settle_reg <= 16'h0000;
        end else if (state_reg != ST_TRUNK_CG) begin
            settle_reg <= {8'h00, `OPW_GATE_SETTLE};
        end else if (settle_reg != 16'h0000) begin
            settle_reg <= settle_reg - 16'h0001;
        end
    end

    // ****************************************************************
    // Clock, power and SRAM controls
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_block_clk_en      <= '1;
            o_core_clk_en       <= 1'b1;
            o_trunk_clk_en      <= 1'b1;
            o_logic_power_en    <= 1'b1;
            o_wrapper_power_req <= 1'b1;
        end else begin
            o_block_clk_en   <= (state_next == ST_BLOCK_CG) ? ~i_block_idle :
                                ((state_next == ST_ON) ? '1 : '0);
            o_core_clk_en    <= !i_wait_for_interrupt_instruction;
            o_trunk_clk_en   <= (state_next == ST_ON) || (state_next == ST_BLOCK_CG);
            o_logic_power_en <= !(state_next inside {ST_RET, ST_DEEP, ST_APG, ST_IAPG});
            o_wrapper_power_req <= !(state_next inside {ST_RET, ST_DEEP, ST_APG, ST_IAPG});
        end
    end

    // Per-bank mode; kept banks follow retention with logic gated, except in ST_DEEP where all banks are power gated
    generate
        for (genvar b = 0; b < NBANK; b++) begin : g_bank
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_bank_mode[b] <= `OPW_BANK_ON;
                end else if (state_next inside {ST_ON, ST_BLOCK_CG, ST_TRUNK_CG}) begin
                    o_bank_mode[b] <= `OPW_BANK_ON;
                end else if (i_bank_keep[b] && (state_next != ST_DEEP)) begin
                    o_bank_mode[b] <= `OPW_BANK_RET;
                end else begin
                    o_bank_mode[b] <= `OPW_BANK_PG;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Wake recording and host wake
    // ****************************************************************
    // Sticky capture; set wins over clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq_pending <= '0;
        end else if (i_irq_clear) begin
            o_irq_pending <= irq_s;
        end else begin
            o_irq_pending <= o_irq_pending | irq_s;
        end
    end

    // Rail request covers firmware fabric use and host active-idle wake
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rail_request        <= 1'b0;
            o_wake_set_bit        <= '0;
            o_wake_assert_message <= 1'b0;
            o_fabric_accessible   <= 1'b1;
        end else begin
            o_rail_request        <= i_fw_rail_request | (i_fw_host_wake & !i_host_in_sleep);
            o_wake_set_bit        <= o_wake_set_bit
                                     | (i_fw_host_wake & i_host_in_sleep ? i_wake_func : '0);
            o_wake_assert_message <= i_fw_host_wake & i_host_in_sleep & ~|i_wake_func;
            o_fabric_accessible   <= (state_next != ST_IAPG);
        end
    end

    // ****************************************************************
    // Resume timing watch
    // ****************************************************************
    logic [31:0] resume_cnt_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            resume_cnt_reg <= '0;
            o_resume_late  <= 1'b0;
        end else if (state_reg inside {ST_ON, ST_BLOCK_CG} || !deep_wake) begin
            resume_cnt_reg <= '0;
        end else begin
            resume_cnt_reg <= resume_cnt_reg + 32'd1;
            o_resume_late  <= o_resume_late | (resume_cnt_reg >= 32'(RESUME_CYCLES));
        end
    end

    assign o_state = state_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_iapg_stuck;
        @(posedge i_clk) disable iff (!i_resetn)
        state_reg == ST_IAPG |=> state_reg == ST_IAPG && !o_fabric_accessible;
    endproperty
    a_iapg_stuck: assert property (p_iapg_stuck) else $error("left inaccessible state");

    property p_shallow_only;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == ST_ON && !all_idle_req && !(ipc_off && others_off))
            |=> state_reg inside {ST_ON, ST_BLOCK_CG};
    endproperty
    a_shallow_only: assert property (p_shallow_only) else $error("too deep without idle");

    property p_apg_entry;
        @(posedge i_clk) disable iff (!i_resetn)
        $rose(state_reg == ST_APG) |-> $past(state_reg) inside {ST_ON, ST_RET, ST_DEEP};
    endproperty
    a_apg_entry: assert property (p_apg_entry) else $error("bad gated entry");

    property p_trunk_gated;
        @(posedge i_clk) disable iff (!i_resetn)
        state_reg == ST_TRUNK_CG |-> !o_trunk_clk_en;
    endproperty
    a_trunk_gated: assert property (p_trunk_gated) else $error("trunk clock running");

    property p_irq_kept;
        @(posedge i_clk) disable iff (!i_resetn)
        |irq_s |=> (o_irq_pending & $past(irq_s)) == $past(irq_s);
    endproperty
    a_irq_kept: assert property (p_irq_kept) else $error("wake interrupt lost");

    property p_deep_wake;
        @(posedge i_clk) disable iff (!i_resetn)
        (deep_wake && state_reg inside {ST_TRUNK_CG, ST_RET, ST_DEEP}) |=> state_reg == ST_ON;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("wake ignored");

    property p_deep_banks;
        @(posedge i_clk) disable iff (!i_resetn)
        state_reg == ST_DEEP ##1 state_reg == ST_DEEP |-> !o_logic_power_en
            && o_bank_mode[0] == `OPW_BANK_PG;
    endproperty
    a_deep_banks: assert property (p_deep_banks) else $error("deep idle not gated");

    property p_wrapper_back;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == ST_ON && $past(state_reg) == ST_APG) |-> o_wrapper_power_req;
    endproperty
    a_wrapper_back: assert property (p_wrapper_back) else $error("wrapper not restored");
endmodule

// ==== include/offload_pwr_cfg.svh ====
// Constants for the offload engine power-state controller
`ifndef OFFLOAD_PWR_CFG_SVH
`define OFFLOAD_PWR_CFG_SVH
`define OPW_RESUME_LIMIT_US   1000
`define OPW_CLK_MHZ           100
`define OPW_RESUME_CYCLES     ((`OPW_RESUME_LIMIT_US * `OPW_CLK_MHZ) - 1)
`define OPW_GATE_SETTLE       8'h04
`define OPW_DSTATE_ON         2'h0
`define OPW_DSTATE_OFF        2'h3
`define OPW_BANK_ON           2'h0
`define OPW_BANK_RET          2'h1
`define OPW_BANK_PG           2'h2
`endif

// ==== include/offload_pwr_pkg.sv ====
// Types for the offload engine power-state controller
package offload_pwr_pkg;
    typedef enum logic [2:0] {
        ST_ON,
        ST_BLOCK_CG,
        ST_TRUNK_CG,
        ST_RET,
        ST_DEEP,
        ST_APG,
        ST_IAPG
    } pwr_state_t;
    typedef logic [1:0] bank_mode_t;
endpackage

// ==== tb/plat_pwr_model.sv ====
// Platform power controller model serving the gated wrapper rail
`timescale 1ns/100ps
module plat_pwr_model #(
    parameter int UP_DLY = 6
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_power_req,
    output logic      o_power_good
);
    int cnt;
    // Rail drops at once on release, ramps back only after a delay
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 0;
            o_power_good <= 1'b1;
        end else if (!i_power_req) begin
            cnt <= 0;
            o_power_good <= 1'b0;
        end else if (cnt < UP_DLY) begin
            cnt <= cnt + 1;
        end else begin
            o_power_good <= 1'b1;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the offload power-state controller
`timescale 1ns/100ps
`include "offload_pwr_cfg.svh"
module testbench;
    import offload_pwr_pkg::*;
    // ************************************************
    // Signals, design and platform model
    // ************************************************
    logic i_clk, i_resetn, i_core_idle, i_ips_idle, i_wait_for_interrupt_instruction;
    logic i_retain_sram, i_enter_inaccessible, i_timer_irq, i_gpio_wake, i_host_access;
    logic i_irq_clear, i_wrapper_power_good, i_fw_rail_request, i_fw_host_wake;
    logic i_host_in_sleep, o_core_clk_en, o_trunk_clk_en, o_logic_power_en;
    logic o_wrapper_power_req, o_fabric_accessible, o_rail_request;
    logic o_wake_assert_message, o_resume_late;
    logic [3:0][1:0]  i_func_dstate;
    logic [3:0]       i_idle_request_deepest, i_bank_keep, i_wake_func, o_wake_set_bit;
    logic [7:0]       i_block_idle, i_irq, o_block_clk_en, o_irq_pending;
    pwr_state_t       o_state;
    bank_mode_t [3:0] o_bank_mode;
    int               err_total = 0;
    int               checked = 0;
    int               cycles = 0;
    int               bad;

    offload_engine_power_state_control #(.RESUME_CYCLES(100)) u_dut (
        .i_clk, .i_resetn, .i_func_dstate, .i_idle_request_deepest, .i_core_idle,
        .i_ips_idle, .i_wait_for_interrupt_instruction, .i_block_idle, .i_retain_sram,
        .i_bank_keep, .i_enter_inaccessible, .i_timer_irq, .i_gpio_wake, .i_host_access,
        .i_irq, .i_irq_clear, .i_wrapper_power_good, .i_fw_rail_request, .i_fw_host_wake,
        .i_host_in_sleep, .i_wake_func, .o_state, .o_block_clk_en, .o_core_clk_en,
        .o_trunk_clk_en, .o_logic_power_en, .o_bank_mode, .o_wrapper_power_req,
        .o_fabric_accessible, .o_irq_pending, .o_rail_request, .o_wake_set_bit,
        .o_wake_assert_message, .o_resume_late
    );
    plat_pwr_model u_pmc (.i_clk, .i_resetn, .i_power_req(o_wrapper_power_req),
        .o_power_good(i_wrapper_power_good));

    // 100 MHz clock and a cycle ceiling against hangs
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t value %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait; the state seen at the end is compared
    task automatic wait_state(input pwr_state_t s, input int lim);
        int n;
        n = 0;
        while (o_state !== s && n < lim) begin
            @(negedge i_clk);
            n++;
        end
        check(o_state, s);
    endtask
    task automatic cold_reset;
        i_resetn = 1'b0;
        repeat (3) @(negedge i_clk);
        i_resetn = 1'b1;
        @(negedge i_clk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************
    // Test sequence
    // ************************************************
    initial begin
        {i_resetn, i_core_idle, i_ips_idle, i_wait_for_interrupt_instruction} = 4'h0;
        {i_retain_sram, i_enter_inaccessible, i_timer_irq, i_gpio_wake} = 4'h0;
        {i_host_access, i_irq_clear, i_fw_rail_request, i_fw_host_wake} = 4'h0;
        i_host_in_sleep = 1'b0;
        {i_func_dstate, i_idle_request_deepest, i_bank_keep, i_wake_func} = 20'h0_0000;
        {i_block_idle, i_irq} = 16'h0000;
        cold_reset();
        check({o_state, o_trunk_clk_en, o_logic_power_en, o_fabric_accessible}, 6'h07);
        check({o_bank_mode, o_irq_pending, o_rail_request}, 17'h0_0000);
        // Not every function asks: block gating is the floor
        {i_core_idle, i_ips_idle, i_wait_for_interrupt_instruction} = 3'h7;
        i_block_idle = 8'hF0;
        i_idle_request_deepest = 4'h7;
        wait_state(ST_BLOCK_CG, 40);
        repeat (30) @(negedge i_clk);
        check(o_state, ST_BLOCK_CG);
        check({o_block_clk_en, o_core_clk_en, o_trunk_clk_en}, 10'h03D);
        i_irq = 8'h20;
        wait_state(ST_ON, 6);
        check(o_irq_pending, 8'h20);
        i_irq = 8'h00;
        i_irq_clear = 1'b1;
        repeat (4) @(negedge i_clk);
        i_irq_clear = 1'b0;
        check(o_irq_pending, 8'h00);
        // Full idle request, retention path, then gated and reachable
        {i_wait_for_interrupt_instruction, i_retain_sram} = 2'h1;
        i_bank_keep = 4'h5;
        i_idle_request_deepest = 4'hF; // Context already saved by firmware
        wait_state(ST_TRUNK_CG, 40);
        check(o_trunk_clk_en, 1'b0);
        wait_state(ST_RET, 20);
        check({o_trunk_clk_en, o_logic_power_en}, 2'h0);
        check(o_bank_mode, {`OPW_BANK_PG, `OPW_BANK_RET, `OPW_BANK_PG, `OPW_BANK_RET});
        wait_state(ST_APG, 30);
        check({o_fabric_accessible, o_wrapper_power_req}, 2'h2);
        {i_idle_request_deepest, i_core_idle, i_timer_irq} = 6'h01;
        wait_state(ST_ON, 100);
        check({o_resume_late, o_wrapper_power_req, o_logic_power_en}, 3'h3);
        i_timer_irq = 1'b0;
        // Wake during gate entry must abort it
        {i_core_idle, i_idle_request_deepest} = 5'h1F;
        wait_state(ST_TRUNK_CG, 40);
        {i_core_idle, i_idle_request_deepest, i_gpio_wake} = 6'h3F; // Idle held, only the wake aborts
        bad = 0;
        repeat (12) begin
            @(negedge i_clk);
            if (o_state === ST_RET || o_state === ST_DEEP) bad = 1;
        end
        check(bad, 0);
        check(o_state, ST_ON);
        i_gpio_wake = 1'b0;
        // Deepest idle, then inaccessible until cold reset
        {i_core_idle, i_idle_request_deepest, i_retain_sram} = 6'h3E;
        wait_state(ST_DEEP, 80);
        check({o_trunk_clk_en, o_logic_power_en}, 2'h0);
        wait_state(ST_APG, 30);
        i_enter_inaccessible = 1'b1;
        wait_state(ST_IAPG, 10);
        check(o_fabric_accessible, 1'b0);
        i_host_access = 1'b1;
        repeat (30) @(negedge i_clk);
        check(o_state, ST_IAPG);
        {i_enter_inaccessible, i_host_access, i_core_idle} = 3'h0;
        i_idle_request_deepest = 4'h0;
        cold_reset();
        check({o_state, o_fabric_accessible, o_logic_power_en}, 5'h03);
        // Deep-off needs every function off plus idle core and IPs
        i_core_idle = 1'b1;
        i_func_dstate = {2'h3, 2'h0, 2'h3, 2'h3};
        repeat (60) @(negedge i_clk);
        check(o_state !== ST_APG, 1'b1);
        i_func_dstate = {4{`OPW_DSTATE_OFF}};
        wait_state(ST_APG, 80);
        {i_func_dstate, i_core_idle, i_host_access} = 10'h001;
        wait_state(ST_ON, 100);
        i_host_access = 1'b0;
        // Host in active idle: the rail request alone wakes it
        i_fw_host_wake = 1'b1;
        repeat (4) @(negedge i_clk);
        check({o_rail_request, o_wake_set_bit, o_wake_assert_message}, 6'h20);
        // Host asleep; firmware holds the rail for its own fabric use
        {i_fw_rail_request, i_host_in_sleep} = 2'h3;
        i_wake_func = 4'h2;
        repeat (4) @(negedge i_clk);
        check(o_rail_request, 1'b1);
        check(o_wake_set_bit, 4'h2);
        i_wake_func = 4'h0;
        repeat (4) @(negedge i_clk);
        check(o_wake_assert_message, 1'b1);
        {i_fw_rail_request, i_fw_host_wake} = 2'h0;
        repeat (4) @(negedge i_clk);
        check({o_rail_request, o_wake_set_bit, o_wake_assert_message}, 6'h04);
        wrap_up();
    end
endmodule
